// file: dv/tks_dbg_sink.sv
`timescale 1ns/1ps
// Lab capture model on the debug side: serves frame bytes, tracks fetches
module tks_dbg_sink (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       frame_active,  // Frame under way
  input  wire logic [6:0] byte_idx,      // Byte asked for
  output      logic [7:0] byte_data,     // Byte served
  output      logic [6:0] max_idx,       // Highest index of this frame
  output      int         frames         // Frames started
);
  logic fa_q;  // Frame state at last edge

  // Byte differs per index, so a stuck index is not hidden
  assign byte_data = {1'b1, byte_idx} ^ 8'h5a;

  // Frame start and highest fetched index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_q <= 1'b0;
      max_idx <= 7'h00;
      frames <= 0;
    end else begin
      fa_q <= frame_active;
      if (frame_active && !fa_q) begin
        frames <= frames + 1;
        max_idx <= 7'h00;
      end else if (frame_active && byte_idx > max_idx) begin
        max_idx <= byte_idx;
      end
    end
  end
endmodule : tks_dbg_sink

// file: dv/tks_setup_timing_test.sv
`timescale 1ns/1ps
`include "tks_map.svh"
module tks_setup_timing_test;
  localparam int MS    = 4;      // Short millisecond for simulation
  localparam int STEP  = MS*100; // Cycles per 100 ms step
  localparam int LIMIT = 40000;  // Hang ceiling in cycles
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        scan_done, scan_permit, burst_active, key_in_detect, key_release;
  logic [4:0]  burst_key;
  logic [15:0] key_signal, key_threshold, key_reference, drop_level;
  logic        any_detect, detect_event, release_event, sleep_req, wake_change;
  logic        change_ack, chg_wire, change_pin_o, change_pin_oe_n, fast_mode;
  logic        drift_hold, line_noise_sync_en, sync_pin, errv;
  logic [2:0]  positive_drift_rate;
  logic [6:0]  dbg_byte_idx, max_idx;
  logic [7:0]  dbg_byte_data;
  int          frames, errors, tests_run, cycles, n, f0;

  tks_setup_timing #(.MS_CYCLES(MS)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_done(scan_done), .scan_permit(scan_permit), .burst_active(burst_active),
    .burst_key(burst_key), .key_signal(key_signal), .key_threshold(key_threshold),
    .key_reference(key_reference), .key_in_detect(key_in_detect),
    .key_release(key_release), .drop_level(drop_level), .any_detect(any_detect),
    .detect_event(detect_event), .release_event(release_event), .sleep_req(sleep_req),
    .wake_change(wake_change), .change_ack(change_ack), .change_pin_i(chg_wire),
    .change_pin_o(change_pin_o), .change_pin_oe_n(change_pin_oe_n),
    .fast_mode(fast_mode), .drift_hold(drift_hold),
    .line_noise_sync_en(line_noise_sync_en), .positive_drift_rate(positive_drift_rate),
    .dbg_byte_idx(dbg_byte_idx), .dbg_byte_data(dbg_byte_data), .sync_pin(sync_pin));
  tks_dbg_sink sink (.pclk(pclk), .presetn(presetn), .frame_active(!scan_permit),
    .byte_idx(dbg_byte_idx), .byte_data(dbg_byte_data), .max_idx(max_idx),
    .frames(frames));

  // Open-drain change line with pull-up
  assign chg_wire = change_pin_oe_n ? 1'b1 : change_pin_o;

  always #25 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick

  // Reset values and an unmapped place
  task automatic t_reset();
    apb(1'b0, `TKS_IDX_DBG_CFG, 8'h00);
    check("cfg", rdv, 32'h00000010);
    apb(1'b0, `TKS_IDX_AWAKE, 8'h00);
    check("awake", rdv, 32'h00000019);
    apb(1'b0, `TKS_IDX_HOLD, 8'h00);
    check("hold", rdv, 32'h00000000);
    apb(1'b0, `TKS_IDX_SCOPE, 8'h00);
    check("scope", rdv, 32'h00000000);
    apb(1'b0, 10'h0ed, 8'h00);
    check("unmapped err", {31'h0, errv}, 32'h1);
  endtask : t_reset

  // Every hysteresis code; release judged only in detection
  task automatic t_hyst();
    key_threshold <= 16'h1000;
    key_reference <= 16'h2000;
    key_signal <= 16'h2000;
    key_in_detect <= 1'b0;
    tick(2);
    check("no release outside detection", {31'h0, key_release}, 32'h0);
    key_in_detect <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `TKS_IDX_DBG_CFG, 8'(c << 4));
      tick(3);
      check("drop level", {16'h0, drop_level}, {16'h0, 16'h1000 + (16'h1000 >> (4 - c))});
      check("release", {31'h0, key_release}, 32'h1);
    end
    // Reference below threshold: drop-out point lies below it
    key_reference <= 16'h0800;
    key_signal <= 16'h0f80;
    apb(1'b1, `TKS_IDX_DBG_CFG, 8'h10);
    tick(3);
    check("drop below", {16'h0, drop_level}, 32'h00000f00);
    check("held above drop", {31'h0, key_release}, 32'h0);
    key_signal <= 16'h0f00;
    tick(3);
    check("release below", {31'h0, key_release}, 32'h1);
    key_in_detect <= 1'b0;
  endtask : t_hyst

  // Frames of each length; the next scan waits; code 0 sends nothing
  task automatic t_debug();
    apb(1'b1, `TKS_IDX_SCOPE, 8'hc0);
    for (int c = 1; c < 5; c++) begin
      apb(1'b1, `TKS_IDX_DBG_CFG, 8'(((c % 4) << 6) | 8'h10));
      f0 = frames;
      @(posedge pclk);
      scan_done <= 1'b1;
      @(posedge pclk);
      scan_done <= 1'b0;
      tick(3);
      check("permit in frame", {31'h0, scan_permit}, {31'h0, c == 4});
      check("first bit", {31'h0, sync_pin}, {31'h0, c < 4});
      scan_done <= 1'b1;
      @(posedge pclk);
      scan_done <= 1'b0;
      for (n = 0; n < 5000 && scan_permit !== 1'b1; n++) @(posedge pclk);
      tick(2);
      check("frames", frames, f0 + (c < 4));
      if (c < 4) check("bytes", {25'h0, max_idx}, (32 << (c - 1)) - 1);
    end
  endtask : t_debug

  // Scope pulse follows one selected key only
  task automatic t_scope();
    apb(1'b1, `TKS_IDX_DBG_CFG, 8'h18);
    apb(1'b1, `TKS_IDX_SCOPE, 8'h2a);
    apb(1'b0, `TKS_IDX_SCOPE, 8'h00);
    check("scope readback", rdv, 32'h0000002a);
    check("drift rate", {29'h0, positive_drift_rate}, 32'h2);
    check("line sync", {31'h0, line_noise_sync_en}, 32'h1);
    burst_active <= 1'b1;
    burst_key <= 5'd5;
    tick(2);
    check("pulse on key", {31'h0, sync_pin}, 32'h1);
    burst_key <= 5'd6;
    tick(2);
    check("pulse other key", {31'h0, sync_pin}, 32'h0);
    burst_active <= 1'b0;
    apb(1'b1, `TKS_IDX_SCOPE, 8'hc0);
    burst_active <= 1'b1;
    burst_key <= 5'd24;
    tick(2);
    check("pulse off code", {31'h0, sync_pin}, 32'h0);
    burst_active <= 1'b0;
  endtask : t_scope

  // Sleep after the awake timeout; change pin and fast mode
  task automatic t_sleep();
    any_detect <= 1'b1;
    apb(1'b1, `TKS_IDX_AWAKE, 8'h02);
    apb(1'b1, `TKS_IDX_DBG_CFG, 8'h11);
    tick(3 * STEP);
    check("no sleep in detection", {31'h0, sleep_req}, 32'h0);
    wake_change <= 1'b1;
    @(posedge pclk);
    wake_change <= 1'b0;
    tick(2);
    check("fast mode", {31'h0, fast_mode}, 32'h1);
    check("change low", {31'h0, chg_wire}, 32'h0);
    any_detect <= 1'b0;
    release_event <= 1'b1;
    @(posedge pclk);
    release_event <= 1'b0;
    tick(STEP - 50);
    check("early sleep", {31'h0, sleep_req}, 32'h0);
    for (n = 0; n < 3 * STEP && sleep_req !== 1'b1; n++) @(posedge pclk);
    tick(2);
    check("sleep", {31'h0, sleep_req}, 32'h1);
    check("fast mode off", {31'h0, fast_mode}, 32'h0);
    // Status: sleep request and change pending only
    apb(1'b0, `TKS_IDX_STATUS, 8'h00);
    check("status", rdv, 32'h00000022);
    change_ack <= 1'b1;
    @(posedge pclk);
    change_ack <= 1'b0;
    tick(2);
    check("change released", {31'h0, chg_wire}, 32'h1);
    apb(1'b1, `TKS_IDX_DBG_CFG, 8'h10);
    tick(3 * STEP);
    check("sleep disabled", {31'h0, sleep_req}, 32'h0);
  endtask : t_sleep

  // Drift hold off at zero, then timed hold
  task automatic t_drift();
    for (int d = 0; d < 3; d += 2) begin
      apb(1'b1, `TKS_IDX_HOLD, 8'(d));
      detect_event <= 1'b1;
      @(posedge pclk);
      detect_event <= 1'b0;
      tick(3);
      check("hold start", {31'h0, drift_hold}, {31'h0, d != 0});
    end
    tick(STEP - 50);
    check("hold kept", {31'h0, drift_hold}, 32'h1);
    for (n = 0; n < 3 * STEP && drift_hold !== 1'b0; n++) @(posedge pclk);
    tick(1);
    check("hold ends", {31'h0, drift_hold}, 32'h0);
  endtask : t_drift

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, scan_done, burst_active} = '0;
    {key_in_detect, any_detect, detect_event, release_event} = '0;
    {wake_change, change_ack} = '0;
    {paddr, pwdata, burst_key, key_signal, key_threshold, key_reference} = '0;
    {errors, tests_run, cycles} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_hyst();
    t_debug();
    t_scope();
    t_sleep();
    t_drift();
    finish_test();
  end
endmodule : tks_setup_timing_test

// file: hw/tks_dbg_if.sv
`timescale 1ns/1ps
// Link between setup logic and debug frame streamer
interface tks_dbg_if;
  logic        start;      // Begin one frame
  logic [7:0]  frame_len;  // Bytes in the frame
  logic [7:0]  byte_data;  // Byte at byte_idx
  logic        busy;       // Frame in progress
  logic [6:0]  byte_idx;   // Byte being fetched
  logic        bit_out;    // Serial bit for the shared pin
  modport ctl  (output start, frame_len, byte_data, input busy, byte_idx, bit_out);
  modport strm (input start, frame_len, byte_data, output busy, byte_idx, bit_out);
endinterface : tks_dbg_if

// file: hw/tks_dbg_streamer.sv
`timescale 1ns/1ps
`include "tks_map.svh"
module tks_dbg_streamer (
  input wire logic pclk,
  input wire logic presetn,
  tks_dbg_if.strm  dbg
);
  tks_pkg::tks_strm_state_t state_q, state_d;  // Frame state
  logic [6:0] idx_q, idx_d;                    // Byte index
  logic [7:0] sh_q, sh_d;                      // Shift register, MSB out first
  logic [2:0] bit_q, bit_d;                    // Bits left in byte
  logic [3:0] div_q, div_d;                    // Bit period divider
  logic [7:0] len_q, len_d;                    // Length latched at start
  logic       last_byte;                       // Current byte closes frame

  // Length is latched so a setup write mid-frame cannot cut the frame short
  assign last_byte = ({1'b0, idx_q} == (len_q - 8'h01));

  // Next state
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    sh_d    = sh_q;
    bit_d   = bit_q;
    div_d   = div_q;
    len_d   = len_q;
    case (state_q)
      tks_pkg::TKS_IDLE: begin
        // Wait for end of keyscan
        if (dbg.start) begin
          idx_d   = 7'h00;
          len_d   = dbg.frame_len;
          state_d = tks_pkg::TKS_LOAD;
        end
      end
      tks_pkg::TKS_LOAD: begin
        // Byte source answers within the cycle
        sh_d    = dbg.byte_data;
        bit_d   = 3'h7;
        div_d   = `TKS_DBG_BIT_DIV;
        state_d = tks_pkg::TKS_SHIFT;
      end
      tks_pkg::TKS_SHIFT: begin
        if (div_q == 4'h0) begin
          div_d = `TKS_DBG_BIT_DIV;
          if (bit_q == 3'h0) begin
            // Byte done
            if (last_byte) begin
              state_d = tks_pkg::TKS_IDLE;
              sh_d    = 8'h00;
            end else begin
              idx_d   = idx_q + 7'h01;
              state_d = tks_pkg::TKS_LOAD;
            end
          end else begin
            sh_d  = {sh_q[6:0], 1'b0};
            bit_d = bit_q - 3'h1;
          end
        end else begin
          div_d = div_q - 4'h1;
        end
      end
      default: state_d = tks_pkg::TKS_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tks_pkg::TKS_IDLE;
      idx_q   <= 7'h00;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      div_q   <= 4'h0;
      len_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      sh_q    <= sh_d;
      bit_q   <= bit_d;
      div_q   <= div_d;
      len_q   <= len_d;
    end
  end

  assign dbg.busy     = (state_q != tks_pkg::TKS_IDLE);
  assign dbg.byte_idx = idx_q;
  assign dbg.bit_out  = sh_q[7];

  // Frame occupies the line for at least eight clock cycles
  AST_FRAME_MIN_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dbg.busy) |-> dbg.busy [*8])
    else $error("Debug frame ended too early");
endmodule : tks_dbg_streamer

// file: hw/tks_map.svh
`ifndef TKS_MAP_SVH
`define TKS_MAP_SVH

// Register indices (byte address is four times the index)
`define TKS_IDX_DBG_CFG    10'h0ee
`define TKS_IDX_AWAKE      10'h0ef
`define TKS_IDX_HOLD       10'h0f0
`define TKS_IDX_SCOPE      10'h0f1
`define TKS_IDX_STATUS     10'h0f8

// Field positions of the mixed setup bytes
`define TKS_DEBUG_MSB      7
`define TKS_DEBUG_LSB      6
`define TKS_HYST_MSB       5
`define TKS_HYST_LSB       4
`define TKS_LNS_BIT        3
`define TKS_SLEEP_MSB      2
`define TKS_SLEEP_LSB      0
`define TKS_SCOPE_MSB      7
`define TKS_SCOPE_LSB      3
`define TKS_DRATE_MSB      2
`define TKS_DRATE_LSB      0

// Reset values
`define TKS_RST_DBG_CFG    8'h10
`define TKS_RST_AWAKE      8'h19
`define TKS_RST_HOLD       8'h00
`define TKS_RST_SCOPE      8'h00

// Scope selection: codes at or above this count switch the pulse off
`define TKS_KEY_COUNT      5'h18

// Frame lengths for debug codes 1, 2 and 3
`define TKS_FRM_LEN1       8'h20
`define TKS_FRM_LEN2       8'h40
`define TKS_FRM_LEN3       8'h80

// Serial bit period of the debug pin, in clock cycles minus one
`define TKS_DBG_BIT_DIV    4'h3

// Timebase
`define TKS_PCLK_NS        50
`define TKS_MS_NS          1000000
`define TKS_MS_CYCLES      (`TKS_MS_NS / `TKS_PCLK_NS)
`define TKS_STEP_MS        7'h64

`endif

// file: hw/tks_pkg.sv
package tks_pkg;
  typedef logic [7:0]  tks_byte_t;   // One setup byte
  typedef logic [15:0] tks_level_t;  // Signal, threshold or reference level
  typedef enum logic [1:0] {TKS_IDLE, TKS_LOAD, TKS_SHIFT} tks_strm_state_t;
endpackage : tks_pkg

// file: hw/tks_setup_timing.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "tks_map.svh"
module tks_setup_timing #(
  parameter int unsigned MS_CYCLES = `TKS_MS_CYCLES  // Clock cycles per millisecond
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        scan_done,
  output      logic        scan_permit,
  input  wire logic        burst_active,
  input  wire logic [4:0]  burst_key,
  input  wire logic [15:0] key_signal,
  input  wire logic [15:0] key_threshold,
  input  wire logic [15:0] key_reference,
  input  wire logic        key_in_detect,
  output      logic        key_release,
  output      logic [15:0] drop_level,
  input  wire logic        any_detect,
  input  wire logic        detect_event,
  input  wire logic        release_event,
  output      logic        sleep_req,
  input  wire logic        wake_change,
  input  wire logic        change_ack,
  input  wire logic        change_pin_i,
  output      logic        change_pin_o,
  output      logic        change_pin_oe_n,
  output      logic        fast_mode,
  output      logic        drift_hold,
  output      logic        line_noise_sync_en,
  output      logic [2:0]  positive_drift_rate,
  output      logic [6:0]  dbg_byte_idx,
  input  wire logic [7:0]  dbg_byte_data,
  output      logic        sync_pin
);
  tks_dbg_if dbg ();  // Link to frame streamer

  tks_pkg::tks_byte_t cfg_q, cfg_d;      // Debug, hysteresis, sync, sleep
  tks_pkg::tks_byte_t awake_q, awake_d;  // Awake timeout in steps
  tks_pkg::tks_byte_t hold_q, hold_d;    // Drift hold time in steps
  tks_pkg::tks_byte_t scope_q, scope_d;  // Scope key select and drift rate
  logic [31:0] prdata_q, prdata_d;       // Read data register
  logic        setup_ph;                 // APB setup cycle
  logic        wr_acc;                   // APB write access
  logic        hit;                      // Address maps to a register
  logic [1:0]  hyst_sel;                 // Release hysteresis code
  logic [1:0]  dbg_code;                 // Debug frame code
  logic [2:0]  sleep_code;               // Sleep duration code
  logic [4:0]  scope_sel;                // Scope pulse key

  assign hyst_sel            = cfg_q[`TKS_HYST_MSB:`TKS_HYST_LSB];
  assign dbg_code            = cfg_q[`TKS_DEBUG_MSB:`TKS_DEBUG_LSB];
  assign sleep_code          = cfg_q[`TKS_SLEEP_MSB:`TKS_SLEEP_LSB];
  assign line_noise_sync_en  = cfg_q[`TKS_LNS_BIT];
  assign scope_sel           = scope_q[`TKS_SCOPE_MSB:`TKS_SCOPE_LSB];
  assign positive_drift_rate = scope_q[`TKS_DRATE_MSB:`TKS_DRATE_LSB];

  // Word-aligned index match
  function automatic logic tks_sel(input logic [11:0] a, input logic [9:0] idx);
    tks_sel = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction : tks_sel

  // Drop-out level: fraction 1/16..1/2 of span from threshold toward reference
  function automatic logic [15:0] tks_drop(input logic [15:0] thr, input logic [15:0] ref_l,
                                           input logic [1:0] code);
    logic [15:0] span;
    logic [15:0] part;
    span = (ref_l >= thr) ? (ref_l - thr) : (thr - ref_l);
    part = span >> (3'h4 - {1'b0, code});
    tks_drop = (ref_l >= thr) ? (thr + part) : (thr - part);
  endfunction : tks_drop

  // ---------------- APB slave ----------------
  // Zero wait states; read data is captured in the setup cycle
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_q;

  // Address decode for error answer
  always_comb begin
    if (tks_sel(paddr, `TKS_IDX_DBG_CFG)) begin
      hit = 1'b1;
    end else if (tks_sel(paddr, `TKS_IDX_AWAKE)) begin
      hit = 1'b1;
    end else if (tks_sel(paddr, `TKS_IDX_HOLD)) begin
      hit = 1'b1;
    end else if (tks_sel(paddr, `TKS_IDX_SCOPE)) begin
      hit = 1'b1;
    end else if (tks_sel(paddr, `TKS_IDX_STATUS)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end
  assign pslverr = psel && penable && !hit;

  // Register writes and read mux
  always_comb begin
    cfg_d    = cfg_q;
    awake_d  = awake_q;
    hold_d   = hold_q;
    scope_d  = scope_q;
    prdata_d = prdata_q;
    if (wr_acc) begin
      // Single global hysteresis and debug setting
      if (tks_sel(paddr, `TKS_IDX_DBG_CFG)) begin
        cfg_d = pwdata[7:0];
      end else if (tks_sel(paddr, `TKS_IDX_AWAKE)) begin
        awake_d = pwdata[7:0];
      end else if (tks_sel(paddr, `TKS_IDX_HOLD)) begin
        hold_d = pwdata[7:0];
      end else if (tks_sel(paddr, `TKS_IDX_SCOPE)) begin
        scope_d = pwdata[7:0];
      end
    end
    if (setup_ph && !pwrite) begin
      if (tks_sel(paddr, `TKS_IDX_DBG_CFG)) begin
        prdata_d = {24'h000000, cfg_q};
      end else if (tks_sel(paddr, `TKS_IDX_AWAKE)) begin
        prdata_d = {24'h000000, awake_q};
      end else if (tks_sel(paddr, `TKS_IDX_HOLD)) begin
        prdata_d = {24'h000000, hold_q};
      end else if (tks_sel(paddr, `TKS_IDX_SCOPE)) begin
        prdata_d = {24'h000000, scope_q};
      end else if (tks_sel(paddr, `TKS_IDX_STATUS)) begin
        prdata_d = {26'h0000000, !change_pin_oe_n, dbg.busy, drift_hold, fast_mode,
                    sleep_req, key_release};
      end else begin
        prdata_d = 32'h00000000;
      end
    end
  end

  // Setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= `TKS_RST_DBG_CFG;
      awake_q  <= `TKS_RST_AWAKE;
      hold_q   <= `TKS_RST_HOLD;
      scope_q  <= `TKS_RST_SCOPE;
      prdata_q <= 32'h00000000;
    end else begin
      cfg_q    <= cfg_d;
      awake_q  <= awake_d;
      hold_q   <= hold_d;
      scope_q  <= scope_d;
      prdata_q <= prdata_d;
    end
  end

  // ---------------- Release hysteresis ----------------
  logic [15:0] drop_d, drop_q;   // Drop-out level
  logic        rel_d, rel_q;     // Key has fallen back past drop-out

  // Only a key already in detection is judged against the drop-out point
  always_comb begin
    drop_d = tks_drop(key_threshold, key_reference, hyst_sel);
    if (!key_in_detect) begin
      rel_d = 1'b0;
    end else if (key_reference >= key_threshold) begin
      rel_d = (key_signal >= drop_d);
    end else begin
      rel_d = (key_signal <= drop_d);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_q <= 16'h0000;
      rel_q  <= 1'b0;
    end else begin
      drop_q <= drop_d;
      rel_q  <= rel_d;
    end
  end
  assign drop_level  = drop_q;
  assign key_release = rel_q;

  // ---------------- Debug frame and scope pin ----------------
  logic sync_d, sync_q;  // Shared pin level

  // A frame starts only when a scan ends with debug on and the line free
  assign dbg.start     = scan_done && (dbg_code != 2'h0) && !dbg.busy;
  assign dbg.frame_len = (dbg_code == 2'h1) ? `TKS_FRM_LEN1 :
                         (dbg_code == 2'h2) ? `TKS_FRM_LEN2 : `TKS_FRM_LEN3;
  assign dbg.byte_data = dbg_byte_data;
  assign dbg_byte_idx  = dbg.byte_idx;
  // Scan core stalls until the frame is out
  assign scan_permit   = !dbg.busy && !dbg.start;

  // Pin carries the frame while busy, else the scope pulse; both on is a host fault
  always_comb begin
    if (dbg.busy) begin
      sync_d = dbg.bit_out;
    end else begin
      sync_d = burst_active && (scope_sel < `TKS_KEY_COUNT) && (burst_key == scope_sel);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end
  assign sync_pin = sync_q;

  tks_dbg_streamer u_strm (
    .pclk    (pclk),
    .presetn (presetn),
    .dbg     (dbg)
  );

  // ---------------- Timebase and timers ----------------
  logic [14:0] ms_q, ms_d;        // Millisecond prescaler
  logic [6:0]  step_q, step_d;    // Milliseconds within a step
  logic        step_tick;         // One pulse per 100 ms
  logic [7:0]  awk_q, awk_d;      // Awake countdown
  logic [7:0]  hcnt_q, hcnt_d;    // Drift hold countdown
  logic        slp_d, slp_q;      // Sleep request
  logic        chg_d, chg_q;      // Change notification
  logic        fast_d, fast_q;    // Fast scan mode

  // Shared steps keep both timers within one step of each other in phase
  assign step_tick = (ms_q == 15'(MS_CYCLES - 1)) && (step_q == (`TKS_STEP_MS - 7'h01));

  always_comb begin
    ms_d      = (ms_q == 15'(MS_CYCLES - 1)) ? 15'h0000 : (ms_q + 15'h0001);
    step_d    = step_q;
    if (ms_q == 15'(MS_CYCLES - 1)) begin
      step_d = step_tick ? 7'h00 : (step_q + 7'h01);
    end
    // Awake timer reloads on release and is held full while any key detects
    awk_d = awk_q;
    if (any_detect || release_event) begin
      awk_d = (awake_q == 8'h00) ? 8'h01 : awake_q;
    end else if (step_tick && (awk_q != 8'h00)) begin
      awk_d = awk_q - 8'h01;
    end
    slp_d = (sleep_code != 3'h0) && !any_detect && !release_event && (awk_d == 8'h00);
    // Drift hold reloads on detection; a zero setting clears any hold
    hcnt_d = hcnt_q;
    if (detect_event) begin
      hcnt_d = hold_q;
    end else if (step_tick && (hcnt_q != 8'h00)) begin
      hcnt_d = hcnt_q - 8'h01;
    end
    // Set wins over acknowledge
    chg_d  = wake_change || (chg_q && !change_ack);
    fast_d = wake_change || (fast_q && !slp_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q      <= 15'h0000;
      step_q    <= 7'h00;
      awk_q     <= 8'h00;
      hcnt_q    <= 8'h00;
      slp_q     <= 1'b0;
      chg_q     <= 1'b0;
      fast_q    <= 1'b0;
    end else begin
      ms_q      <= ms_d;
      step_q    <= step_d;
      awk_q     <= awk_d;
      hcnt_q    <= hcnt_d;
      slp_q     <= slp_d;
      chg_q     <= chg_d;
      fast_q    <= fast_d;
    end
  end
  assign sleep_req       = slp_q;
  assign drift_hold      = (hcnt_q != 8'h00);
  assign fast_mode       = fast_q;
  // Open drain: pulled low while a change is pending
  assign change_pin_o    = 1'b0;
  assign change_pin_oe_n = !chg_q;

  // ---------------- Checks ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RELEASE_NEEDS_DETECT: assert property (key_release |-> $past(key_in_detect))
    else $error("Release seen for a key not in detection");
  AST_DROP_HALF: assert property ((hyst_sel == 2'h3 && key_reference >= key_threshold) |=>
    drop_level == 16'($past(key_threshold) + (($past(key_reference) - $past(key_threshold)) >> 1)))
    else $error("Half span drop-out level wrong");
  AST_DROP_EIGHTH: assert property ((hyst_sel == 2'h1 && key_reference < key_threshold) |=>
    drop_level == 16'($past(key_threshold) - (($past(key_threshold) - $past(key_reference)) >> 3)))
    else $error("Eighth span drop-out level wrong");
  AST_FRAME_START: assert property ((scan_done && dbg_code != 2'h0 && !dbg.busy) |=>
    dbg.busy [*2])
    else $error("Frame did not start after scan");
  AST_FRAME_HOLDS_SCAN: assert property (dbg.busy |-> !scan_permit)
    else $error("Scan allowed during frame");
  AST_NO_SLEEP_IN_DETECT: assert property (any_detect |=> !sleep_req)
    else $error("Sleep requested with key in detection");
  AST_SLEEP_OFF: assert property ((sleep_code == 3'h0) |=> !sleep_req)
    else $error("Sleep requested while sleep disabled");
  AST_AWAKE_RELOAD: assert property (release_event |=> (awk_q == $past(awake_q) ||
    ($past(awake_q) == 8'h00 && awk_q == 8'h01)))
    else $error("Awake timer not reloaded on release");
  AST_DRIFT_HOLD: assert property ((detect_event && hold_q != 8'h00) |=> drift_hold [*2])
    else $error("Drift hold not asserted after detection");
  AST_DRIFT_ZERO: assert property ((detect_event && hold_q == 8'h00) |=> !drift_hold)
    else $error("Drift hold active with zero setting");
  AST_SCOPE_ONE_KEY: assert property ((sync_pin && !$past(dbg.busy)) |->
    ($past(burst_active) && $past(burst_key) == $past(scope_sel) && $past(scope_sel) < 5'h18))
    else $error("Scope pulse outside selected burst");
  AST_WAKE_CHANGE: assert property (wake_change |=> (!change_pin_oe_n && fast_mode))
    else $error("Wake change did not raise notification");
endmodule : tks_setup_timing
